// ### hdl/sdp_pkg.sv
// Constants shared by the dual port burst RAM
package sdp_pkg;
   localparam int SDP_ADDR_W = 13;
   localparam int SDP_DATA_W = 18;
   localparam int SDP_LANE_W = 9;
   localparam int SDP_LOW_LSB = 0;
   localparam int SDP_HIGH_LSB = 9;
   localparam logic SDP_LAT_FLOW = 1'b0;
   localparam logic SDP_LAT_PIPE = 1'b1;
endpackage

// ### hdl/sdp_port.sv
// One port of the dual port RAM: input registers, burst counter, output path
`timescale 1ns/1ns
module sdp_port
   import sdp_pkg::*;
#(
   parameter int ADDR_W = SDP_ADDR_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [SDP_DATA_W-1:0] wdata_i,
   input wire logic select_active_low_i,
   input wire logic select_active_high_i,
   input wire logic write_n_i,
   input wire logic low_lane_select_n_i,
   input wire logic high_lane_select_n_i,
   input wire logic out_enable_n_i,
   input wire logic latency_select_i,
   input wire logic addr_load_strobe_n_i,
   input wire logic count_advance_n_i,
   input wire logic count_clear_n_i,
   input wire logic [SDP_DATA_W-1:0] array_rdata_i,
   output logic [ADDR_W-1:0] array_addr_o,
   output logic [SDP_DATA_W-1:0] array_wdata_o,
   output logic [1:0] array_lane_we_o,
   output logic [SDP_DATA_W-1:0] data_o,
   output logic [SDP_DATA_W-1:0] data_oe_o,
   output logic selected_o
);

   typedef struct packed {
      logic [ADDR_W-1:0] cnt;
      logic [ADDR_W-1:0] acc_addr;
      logic [SDP_DATA_W-1:0] wdata;
      logic sel;
      logic rd;
      logic wr;
      logic [1:0] lane;
      logic pipe;
      logic [SDP_DATA_W-1:0] pipe_data;
      logic pipe_rd;
      logic [1:0] pipe_lane;
   } sdp_port_state_type;

   sdp_port_state_type st_ff;
   sdp_port_state_type nxt_st;
   logic sel_now;
   logic [ADDR_W-1:0] eff_addr;
   logic [ADDR_W-1:0] cnt_plus;

   assign sel_now = !select_active_low_i && select_active_high_i;
   assign cnt_plus = st_ff.cnt + {{(ADDR_W-1){1'b0}}, 1'b1};

   // -----------------------------------------------------------------
   // Address source and counter
   // -----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // Counter runs regardless of selects
      if (!count_clear_n_i) begin
         eff_addr = '0;
         nxt_st.cnt = '0;
      end else if (!addr_load_strobe_n_i) begin
         eff_addr = addr_i;
         nxt_st.cnt = addr_i;
      end else if (!count_advance_n_i) begin
         eff_addr = cnt_plus;
         nxt_st.cnt = cnt_plus;
      end else begin
         eff_addr = st_ff.cnt;
      end
      // Registered access on this edge
      nxt_st.acc_addr = eff_addr;
      nxt_st.wdata = wdata_i;
      nxt_st.sel = sel_now;
      nxt_st.wr = sel_now && !write_n_i;
      nxt_st.rd = sel_now && write_n_i;
      nxt_st.lane = {!high_lane_select_n_i, !low_lane_select_n_i};
      nxt_st.pipe = latency_select_i;
      // Output register only feeds data in pipelined mode
      nxt_st.pipe_data = array_rdata_i;
      nxt_st.pipe_rd = st_ff.rd;
      nxt_st.pipe_lane = st_ff.lane;
      if (!rst_n_i) begin
         nxt_st = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_ff <= nxt_st;
   end

   // -----------------------------------------------------------------
   // Array side and output drivers
   // -----------------------------------------------------------------
   // Write request stands for this cycle's access; the array commits it on the core clock edge
   assign array_addr_o = st_ff.acc_addr;
   assign array_wdata_o = st_ff.wdata;
   assign array_lane_we_o = st_ff.wr ? st_ff.lane : 2'b00;

   logic drv_rd;
   logic [1:0] drv_lane;
   always_comb begin
      if (st_ff.pipe == SDP_LAT_PIPE) begin
         data_o = st_ff.pipe_data;
         drv_rd = st_ff.pipe_rd;
         drv_lane = st_ff.pipe_lane;
      end else begin
         data_o = array_rdata_i;
         drv_rd = st_ff.rd;
         drv_lane = st_ff.lane;
      end
   end

   // Output enable is purely combinational so it acts between edges
   assign data_oe_o = {{SDP_LANE_W{drv_rd && drv_lane[1] && !out_enable_n_i}},
                       {SDP_LANE_W{drv_rd && drv_lane[0] && !out_enable_n_i}}};
   assign selected_o = st_ff.sel;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_clear_wins;
      @(posedge clk_i) disable iff (!rst_n_i)
         !count_clear_n_i |=> st_ff.cnt == '0;
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("counter not cleared");

   property p_load;
      @(posedge clk_i) disable iff (!rst_n_i)
         count_clear_n_i && !addr_load_strobe_n_i |=> st_ff.cnt == $past(addr_i);
   endproperty
   a_load: assert property (p_load) else $error("counter not loaded");

   property p_advance;
      @(posedge clk_i) disable iff (!rst_n_i)
         count_clear_n_i && addr_load_strobe_n_i && !count_advance_n_i
         |=> st_ff.cnt == $past(cnt_plus);
   endproperty
   a_advance: assert property (p_advance) else $error("counter did not step");

   property p_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
         count_clear_n_i && addr_load_strobe_n_i && count_advance_n_i |=> $stable(st_ff.cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved while held");

   property p_write_sel;
      @(posedge clk_i) disable iff (!rst_n_i)
         (select_active_low_i || !select_active_high_i) |=> array_lane_we_o == 2'b00;
   endproperty
   a_write_sel: assert property (p_write_sel) else $error("write while deselected");

   property p_no_drive_oe;
      @(posedge clk_i) disable iff (!rst_n_i)
         out_enable_n_i |-> data_oe_o == '0;
   endproperty
   a_no_drive_oe: assert property (p_no_drive_oe) else $error("driven with output disabled");

   property p_pipe_latency;
      @(posedge clk_i) disable iff (!rst_n_i)
         !(sel_now && write_n_i) ##1 sel_now && write_n_i && !low_lane_select_n_i && latency_select_i
         ##1 latency_select_i && !out_enable_n_i |-> !data_oe_o[0] ##1 (data_oe_o[0] || out_enable_n_i);
   endproperty
   a_pipe_latency: assert property (p_pipe_latency) else $error("pipelined read too early");

   property p_flow_read;
      @(posedge clk_i) disable iff (!rst_n_i)
         sel_now && write_n_i && !low_lane_select_n_i && !latency_select_i
         ##1 !out_enable_n_i |-> data_oe_o[0];
   endproperty
   a_flow_read: assert property (p_flow_read) else $error("flow-through read not driven");

   property p_pipe_reselect;
      @(posedge clk_i) disable iff (!rst_n_i)
         !sel_now ##1 latency_select_i |=> data_oe_o == '0;
   endproperty
   a_pipe_reselect: assert property (p_pipe_reselect) else $error("pipelined drive right after deselect");
endmodule

// ### hdl/sdp_ram.sv
// Dual port burst RAM top: shared array and two separately clocked ports
`timescale 1ns/1ns
module sdp_ram
   import sdp_pkg::*;
#(
   parameter int ADDR_W = SDP_ADDR_W
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic b_clk_i,
   input wire logic b_rst_n_i,
   input wire logic [ADDR_W-1:0] a_addr_i,
   input wire logic [SDP_DATA_W-1:0] a_data_i,
   input wire logic a_select_active_low_i,
   input wire logic a_select_active_high_i,
   input wire logic a_write_n_i,
   input wire logic a_low_lane_select_n_i,
   input wire logic a_high_lane_select_n_i,
   input wire logic a_out_enable_n_i,
   input wire logic a_latency_select_i,
   input wire logic a_addr_load_strobe_n_i,
   input wire logic a_count_advance_n_i,
   input wire logic a_count_clear_n_i,
   output logic [SDP_DATA_W-1:0] a_data_o,
   output logic [SDP_DATA_W-1:0] a_data_oe_o,
   output logic a_selected_o,
   input wire logic [ADDR_W-1:0] b_addr_i,
   input wire logic [SDP_DATA_W-1:0] b_data_i,
   input wire logic b_select_active_low_i,
   input wire logic b_select_active_high_i,
   input wire logic b_write_n_i,
   input wire logic b_low_lane_select_n_i,
   input wire logic b_high_lane_select_n_i,
   input wire logic b_out_enable_n_i,
   input wire logic b_latency_select_i,
   input wire logic b_addr_load_strobe_n_i,
   input wire logic b_count_advance_n_i,
   input wire logic b_count_clear_n_i,
   output logic [SDP_DATA_W-1:0] b_data_o,
   output logic [SDP_DATA_W-1:0] b_data_oe_o,
   output logic b_selected_o
);

   // -----------------------------------------------------------------
   // Shared storage
   // -----------------------------------------------------------------
   localparam int DEPTH = 1 << ADDR_W;
   logic [SDP_DATA_W-1:0] mem [DEPTH];
   logic [ADDR_W-1:0] a_arr_addr;
   logic [ADDR_W-1:0] b_arr_addr;
   logic [SDP_DATA_W-1:0] a_arr_wdata;
   logic [SDP_DATA_W-1:0] b_arr_wdata;
   logic [1:0] a_lane_we;
   logic [1:0] b_lane_we;
   logic [SDP_DATA_W-1:0] a_rdata;
   logic [SDP_DATA_W-1:0] b_rdata;
   logic [1:0] b_lane_we_sync;
   logic [ADDR_W-1:0] b_addr_sync;
   logic [SDP_DATA_W-1:0] b_wdata_sync;

   // Read is asynchronous so flow-through data shows within the access cycle
   assign a_rdata = mem[a_arr_addr];
   assign b_rdata = mem[b_arr_addr];

   // Both ports commit their writes on the core clock edge, port B's included.
   // Same-word, same-lane collisions from both ports go to port B, whose write is applied last.
   always_ff @(posedge core_clk_i) begin
      if (a_lane_we[0]) begin
         mem[a_arr_addr][SDP_LOW_LSB +: SDP_LANE_W] <= a_arr_wdata[SDP_LOW_LSB +: SDP_LANE_W];
      end
      if (a_lane_we[1]) begin
         mem[a_arr_addr][SDP_HIGH_LSB +: SDP_LANE_W] <= a_arr_wdata[SDP_HIGH_LSB +: SDP_LANE_W];
      end
      if (b_lane_we_sync[0]) begin
         mem[b_addr_sync][SDP_LOW_LSB +: SDP_LANE_W] <= b_wdata_sync[SDP_LOW_LSB +: SDP_LANE_W];
      end
      if (b_lane_we_sync[1]) begin
         mem[b_addr_sync][SDP_HIGH_LSB +: SDP_LANE_W] <= b_wdata_sync[SDP_HIGH_LSB +: SDP_LANE_W];
      end
   end

   // -----------------------------------------------------------------
   // Port B write capture
   // -----------------------------------------------------------------
   // One writer process keeps the array synthesizable; port B's write
   // is sampled on the array clock, so the two port clocks are assumed
   // related and port B must hold its write one array cycle.
   assign b_lane_we_sync = b_lane_we;
   assign b_addr_sync = b_arr_addr;
   assign b_wdata_sync = b_arr_wdata;

   // -----------------------------------------------------------------
   // Ports
   // -----------------------------------------------------------------
   sdp_port #(.ADDR_W(ADDR_W)) u_port_a (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(a_addr_i),
      .wdata_i(a_data_i),
      .select_active_low_i(a_select_active_low_i),
      .select_active_high_i(a_select_active_high_i),
      .write_n_i(a_write_n_i),
      .low_lane_select_n_i(a_low_lane_select_n_i),
      .high_lane_select_n_i(a_high_lane_select_n_i),
      .out_enable_n_i(a_out_enable_n_i),
      .latency_select_i(a_latency_select_i),
      .addr_load_strobe_n_i(a_addr_load_strobe_n_i),
      .count_advance_n_i(a_count_advance_n_i),
      .count_clear_n_i(a_count_clear_n_i),
      .array_rdata_i(a_rdata),
      .array_addr_o(a_arr_addr),
      .array_wdata_o(a_arr_wdata),
      .array_lane_we_o(a_lane_we),
      .data_o(a_data_o),
      .data_oe_o(a_data_oe_o),
      .selected_o(a_selected_o)
   );

   sdp_port #(.ADDR_W(ADDR_W)) u_port_b (
      .clk_i(b_clk_i),
      .rst_n_i(b_rst_n_i),
      .addr_i(b_addr_i),
      .wdata_i(b_data_i),
      .select_active_low_i(b_select_active_low_i),
      .select_active_high_i(b_select_active_high_i),
      .write_n_i(b_write_n_i),
      .low_lane_select_n_i(b_low_lane_select_n_i),
      .high_lane_select_n_i(b_high_lane_select_n_i),
      .out_enable_n_i(b_out_enable_n_i),
      .latency_select_i(b_latency_select_i),
      .addr_load_strobe_n_i(b_addr_load_strobe_n_i),
      .count_advance_n_i(b_count_advance_n_i),
      .count_clear_n_i(b_count_clear_n_i),
      .array_rdata_i(b_rdata),
      .array_addr_o(b_arr_addr),
      .array_wdata_o(b_arr_wdata),
      .array_lane_we_o(b_lane_we),
      .data_o(b_data_o),
      .data_oe_o(b_data_oe_o),
      .selected_o(b_selected_o)
   );
endmodule

// ### tb/sdp_host_model.sv
// Host controller model on port B: half-rate clock, single-word writes and reads
`timescale 1ns/1ns
module sdp_host_model
   import sdp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   output logic b_clk_o,
   output logic b_rst_n_o,
   output logic [SDP_ADDR_W-1:0] b_addr_o,
   output logic [SDP_DATA_W-1:0] b_data_o,
   output logic [9:0] b_ctl_o,
   input wire logic [SDP_DATA_W-1:0] b_data_i,
   input wire logic [SDP_DATA_W-1:0] b_data_oe_i
);
   // Edges aligned to core clock, so a B write stands two full core cycles
   initial b_clk_o = 1'b0;
   always @(posedge core_clk_i) b_clk_o <= ~b_clk_o;
   assign b_rst_n_o = rst_n_i;
   // Order: sel_n sel wr_n high_n low_n oe_n lat ld_n adv_n clr_n
   initial begin
      b_ctl_o = 10'h283;
      b_addr_o = 13'h0;
      b_data_o = 18'h0;
   end
   // Callers keep B writes off any word that A writes at the same time
   task automatic xfer(input logic wr, input logic [12:0] a, input logic [17:0] d,
      output logic [17:0] q, output logic [17:0] qe);
      @(posedge b_clk_o);
      #10;
      b_ctl_o[9:7] = {2'b01, ~wr};
      b_addr_o = a;
      b_data_o = d;
      @(posedge b_clk_o);
      #10;
      b_ctl_o[9:7] = 3'b101;
      // Released lines never keep the last value
      b_addr_o = ~a;
      b_data_o = ~d;
      // Mid core cycle, clear of the array's write edge
      @(negedge core_clk_i);
      q = b_data_i;
      qe = b_data_oe_i;
   endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench: port A driven here, port B through the host model
`timescale 1ns/1ns
module testbench;
   import sdp_pkg::*;
   typedef struct {int due; logic [17:0] d; logic [17:0] oe; logic sel; bit pipe;} sdp_note_type;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [12:0] a_addr = 13'h0;
   logic [17:0] a_data = 18'h0;
   logic a_sel_n = 1'b1, a_sel = 1'b0, a_wr_n = 1'b1, a_low_n = 1'b0, a_high_n = 1'b0;
   logic a_oe_n = 1'b0, a_lat = 1'b0, a_ld_n = 1'b0, a_adv_n = 1'b1, a_clr_n = 1'b1;
   logic [17:0] a_q, a_qe, b_q, b_qe, b_rd, b_wd, b_oe;
   logic a_seen_sel, b_seen_sel;
   logic b_clk, b_rst_n;
   logic [12:0] b_addr;
   logic [9:0] b_ctl;
   logic [17:0] shadow [int];
   logic [12:0] cnt = 13'h0;
   logic [31:0] rs = 32'h0000ec80;
   logic [31:0] rv;
   int cyc = 0;
   int n_tests = 0;
   int n_mismatch = 0;
   sdp_note_type q [$];
   sdp_note_type nt;

   sdp_ram dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .b_clk_i(b_clk), .b_rst_n_i(b_rst_n),
      .a_addr_i(a_addr), .a_data_i(a_data), .a_select_active_low_i(a_sel_n), .a_select_active_high_i(a_sel),
      .a_write_n_i(a_wr_n), .a_low_lane_select_n_i(a_low_n), .a_high_lane_select_n_i(a_high_n),
      .a_out_enable_n_i(a_oe_n), .a_latency_select_i(a_lat), .a_addr_load_strobe_n_i(a_ld_n),
      .a_count_advance_n_i(a_adv_n), .a_count_clear_n_i(a_clr_n), .a_data_o(a_q), .a_data_oe_o(a_qe),
      .a_selected_o(a_seen_sel), .b_addr_i(b_addr), .b_data_i(b_wd), .b_select_active_low_i(b_ctl[9]),
      .b_select_active_high_i(b_ctl[8]), .b_write_n_i(b_ctl[7]), .b_high_lane_select_n_i(b_ctl[6]),
      .b_low_lane_select_n_i(b_ctl[5]), .b_out_enable_n_i(b_ctl[4]), .b_latency_select_i(b_ctl[3]),
      .b_addr_load_strobe_n_i(b_ctl[2]), .b_count_advance_n_i(b_ctl[1]), .b_count_clear_n_i(b_ctl[0]),
      .b_data_o(b_rd), .b_data_oe_o(b_oe), .b_selected_o(b_seen_sel));
   sdp_host_model host (.core_clk_i(core_clk), .rst_n_i(rst_n), .b_clk_o(b_clk), .b_rst_n_o(b_rst_n),
      .b_addr_o(b_addr), .b_data_o(b_wd), .b_ctl_o(b_ctl), .b_data_i(b_rd), .b_data_oe_i(b_oe));

   initial forever #50 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ----------------------------------------
   // Port A access; ctl = ld_n adv_n clr_n, s = sel sel_n
   // ----------------------------------------
   task automatic acc(input logic wr, input logic [12:0] a, input logic [17:0] d, input logic [1:0] ln_n,
      input logic [2:0] ctl, input logic [1:0] s);
      logic [17:0] lm;
      sdp_note_type n;
      @(posedge core_clk);
      #10;
      {a_addr, a_data, a_wr_n, a_high_n, a_low_n} = {a, d, ~wr, ln_n};
      {a_ld_n, a_adv_n, a_clr_n, a_sel, a_sel_n} = {ctl, s};
      // Counter mirror, clear over load over advance
      cnt = !ctl[0] ? 13'h0 : !ctl[2] ? a : !ctl[1] ? cnt + 13'h1 : cnt;
      lm = {{9{~ln_n[1]}}, {9{~ln_n[0]}}};
      if (s == 2'b10 && wr) shadow[cnt] = (shadow[cnt] & ~lm) | (d & lm);
      if (!wr) begin
         n.due = cyc + 1 + int'(a_lat);
         n.oe = (s == 2'b10 && !a_oe_n) ? lm : 18'h0;
         n.d = shadow[cnt] & n.oe;
         n.sel = (s == 2'b10);
         n.pipe = a_lat;
         q.push_back(n);
      end
   endtask

   always @(negedge core_clk) begin
      while (q.size() > 0 && q[0].due == cyc) begin
         nt = q.pop_front();
         chk("a_data_oe", nt.oe, a_qe);
         chk("a_data", nt.d, a_q & nt.oe);
         // Select flag only belongs to this access one cycle after capture
         if (!nt.pipe) chk("a_selected", {17'h0, nt.sel}, {17'h0, a_seen_sel});
      end
   end

   task automatic tally_and_finish();
      // A note never compared is a missed answer
      if (q.size() != 0) n_mismatch++;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_mismatch++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      #10;
      rst_n = 1'b1;
      for (int i = 0; i < 16; i++) acc(1'b1, 13'(i), 18'(xs()), 2'b00, 3'b011, 2'b10);
      for (int i = 0; i < 16; i++) acc(1'b0, 13'(i), 18'h0, 2'b00, 3'b011, 2'b10);
      acc(1'b1, 13'h3, 18'h3ffff, 2'b10, 3'b011, 2'b10);
      acc(1'b0, 13'h3, 18'h0, 2'b00, 3'b011, 2'b10);
      acc(1'b0, 13'h3, 18'h0, 2'b01, 3'b011, 2'b10);
      // Let the lane check finish before output enable drops
      repeat (2) @(posedge core_clk);
      #10;
      a_oe_n = 1'b1;
      acc(1'b0, 13'h4, 18'h0, 2'b00, 3'b011, 2'b10);
      acc(1'b1, 13'h4, 18'h0, 2'b00, 3'b011, 2'b11);
      acc(1'b1, 13'h5, 18'h0, 2'b00, 3'b011, 2'b00);
      a_oe_n = 1'b0;
      for (int i = 4; i < 6; i++) acc(1'b0, 13'(i), 18'h0, 2'b00, 3'b011, 2'b10);
      acc(1'b1, 13'h6, 18'h1, 2'b00, 3'b011, 2'b10);
      a_lat = SDP_LAT_PIPE;
      for (int i = 0; i < 8; i++) acc(1'b0, 13'(i), 18'h0, 2'b00, 3'b011, 2'b10);
      acc(1'b0, 13'h1, 18'h0, 2'b00, 3'b011, 2'b11);
      acc(1'b0, 13'h2, 18'h0, 2'b00, 3'b011, 2'b10);
      repeat (2) acc(1'b1, 13'h6, 18'h2, 2'b00, 3'b011, 2'b10);
      a_lat = SDP_LAT_FLOW;
      acc(1'b1, 13'h100, 18'(xs()), 2'b00, 3'b010, 2'b10);
      repeat (3) acc(1'b1, 13'h0, 18'(xs()), 2'b00, 3'b101, 2'b10);
      acc(1'b1, 13'h0, 18'(xs()), 2'b00, 3'b111, 2'b10);
      acc(1'b1, 13'h9, 18'(xs()), 2'b00, 3'b001, 2'b10);
      acc(1'b1, 13'h1fff, 18'(xs()), 2'b00, 3'b011, 2'b10);
      acc(1'b1, 13'h0, 18'(xs()), 2'b00, 3'b101, 2'b10);
      acc(1'b0, 13'h1ffe, 18'h0, 2'b00, 3'b011, 2'b11);
      acc(1'b0, 13'h0, 18'h0, 2'b00, 3'b101, 2'b10);
      for (int i = 0; i < 10; i++) acc(1'b0, 13'(i), 18'h0, 2'b00, 3'b011, 2'b10);
      for (int i = 0; i < 40; i++) begin
         rv = xs();
         acc(rv[0], 13'(rv[4:1]), 18'(xs()), rv[6:5], 3'b011, rv[8:7] == 2'b00 ? 2'b11 : 2'b10);
      end
      fork
         acc(1'b1, 13'h20, 18'h2a5a5, 2'b00, 3'b011, 2'b10);
         host.xfer(1'b1, 13'h21, 18'h15a5a, b_q, b_qe);
      join
      shadow[13'h21] = 18'h15a5a;
      host.xfer(1'b0, 13'h20, 18'h0, b_q, b_qe);
      chk("b_data", 18'h2a5a5, b_q);
      chk("b_data_oe", 18'h3ffff, b_qe);
      chk("b_selected", 18'h1, {17'h0, b_seen_sel});
      acc(1'b0, 13'h21, 18'h0, 2'b00, 3'b011, 2'b10);
      repeat (4) @(posedge core_clk);
      tally_and_finish();
   end
endmodule
